// >>> logic/bit_skip_instr_unit.sv
// Bit-set and skip instruction unit of a 4-bit core, with APB access.
// Assumes one word per instrValid pulse and an instruction-rate clock enable.
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module bit_skip_instr_unit
   import bit_skip_pkg::*;
#(
   parameter int MEM_AW = 6
) (
   input  wire logic              clock,
   input  wire logic              reset,
   input  wire logic              instrValid,
   input  wire logic [9:0]        instrWord,
   input  wire logic [MEM_AW-1:0] dataPointer,
   input  wire logic [2:0]        regY,
   input  wire logic [3:0]        accumulator,
   input  wire logic              carryFlag,
   input  wire logic              powerDownFlag,
   input  wire logic              extIrq0Pin,
   input  wire logic              extIrq1Pin,
   input  wire logic [NUM_FL-1:0] flagSetPulse,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   output logic                   skipNext,
   output logic [4:0]             portD,
   output logic                   pageBankFlag,
   output logic                   tableHighBitsEnable,
   output logic [NUM_FL-1:0]      requestFlags,
   output logic                   irq
);
   logic [3:0]        mem_q [2**MEM_AW];
   logic [3:0]        ctrl1_q, ctrl2_q;
   logic [1:0]        pol_q;
   logic [NUM_EV-1:0] evSt_q, evMsk_q;
   logic [1:0]        pin0Sync_q, pin1Sync_q;
   logic [4:0]        portD_q;
   logic [NUM_FL-1:0] flags_q, flagClr;
   logic              bank_q, upper_q;
   logic [31:0]       prdata_q;
   exec_t             state_q, state_d;
   logic              skip_d, portErr;
   logic [3:0]        memNib;
   logic              apbWr, apbRd, pin0, pin1;

   assign apbWr = psel && penable && pwrite;
   assign apbRd = psel && penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign prdata = prdata_q;
   assign memNib = mem_q[dataPointer];
   assign pin0 = pin0Sync_q[1];
   assign pin1 = pin1Sync_q[1];

   // Pins are asynchronous, two flops before use
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pin0Sync_q <= 2'h0;
         pin1Sync_q <= 2'h0;
      end else begin
         pin0Sync_q <= {pin0Sync_q[0], extIrq0Pin};
         pin1Sync_q <= {pin1Sync_q[0], extIrq1Pin};
      end
   end

   // Decode and skip decision
   always_comb begin
      state_d = state_q;
      skip_d = 1'b0;
      flagClr = '0;
      portErr = 1'b0;
      if (instrValid) begin
         case (state_q)
            EXEC_SKIP: state_d = EXEC_NORMAL; // Word dropped, no side effect
            EXEC_WAIT_IMM: begin
               skip_d = (accumulator == instrWord[3:0]);
               state_d = skip_d ? EXEC_SKIP : EXEC_NORMAL;
            end
            EXEC_WAIT_PORTD: begin
               skip_d = (portD_q[regY] == 1'b0);
               state_d = skip_d ? EXEC_SKIP : EXEC_NORMAL;
            end
            EXEC_NORMAL: begin
               if (instrWord == OP_SKIP_ACC_EQ_IMM) state_d = EXEC_WAIT_IMM;
               else if (instrWord == OP_TEST_PORT_D_ZERO) state_d = EXEC_WAIT_PORTD;
               else begin
                  case (instrWord)
                     OP_SKIP_ACC_EQ_MEM: skip_d = (accumulator == memNib);
                     OP_TEST_EXT0: if (!ctrl1_q[EN_EXT0]) begin
                        skip_d = flags_q[FL_EXT0];
                        flagClr[FL_EXT0] = 1'b1;
                     end
                     OP_TEST_EXT1: if (!ctrl1_q[EN_EXT1]) begin
                        skip_d = flags_q[FL_EXT1];
                        flagClr[FL_EXT1] = 1'b1;
                     end
                     OP_TEST_PIN0: skip_d = (pin0 == pol_q[0]);
                     OP_TEST_PIN1: skip_d = (pin1 == pol_q[1]);
                     OP_TEST_POWER_DOWN: skip_d = powerDownFlag;
                     OP_TEST_TIMER1: if (!ctrl1_q[EN_TIMER1]) begin
                        skip_d = flags_q[FL_T1];
                        flagClr[FL_T1] = 1'b1;
                     end
                     OP_TEST_TIMER2: if (!ctrl1_q[EN_TIMER2]) begin
                        skip_d = flags_q[FL_T2];
                        flagClr[FL_T2] = 1'b1;
                     end
                     OP_TEST_TIMER3: if (!ctrl2_q[EN_TIMER3]) begin
                        skip_d = flags_q[FL_T3];
                        flagClr[FL_T3] = 1'b1;
                     end
                     OP_TEST_VDET: if (!ctrl2_q[EN_VDET]) skip_d = flags_q[FL_VDET];
                     OP_TEST_CARRY_ZERO: skip_d = !carryFlag;
                     OP_SET_PORT_D_BIT: portErr = (regY > PORT_D_MAX);
                     default: begin
                        if ((instrWord & MASK_BIT_FIELD) == OP_TEST_MEM_BIT_ZERO)
                           skip_d = !memNib[instrWord[1:0]];
                     end
                  endcase
                  if (skip_d) state_d = EXEC_SKIP;
               end
            end
            default: state_d = EXEC_NORMAL;
         endcase
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_q <= EXEC_NORMAL;
         skipNext <= 1'b0;
      end else begin
         state_q <= state_d;
         if (instrValid) skipNext <= skip_d;
      end
   end

   wire execNormal = instrValid && (state_q == EXEC_NORMAL);

   // Data memory: bit set by instruction; writes outside skip only
   always_ff @(posedge clock) begin
      if (execNormal && (instrWord & MASK_BIT_FIELD) == OP_SET_MEMORY_BIT)
         mem_q[dataPointer][instrWord[1:0]] <= 1'b1;
   end

   // Port D; a bus write wins over the instruction in one cycle
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         portD_q <= 5'h00;
      end else if (apbWr && paddr == ADDR_PORT_D) begin
         portD_q <= pwdata[4:0];
      end else if (execNormal) begin
         // Y beyond 4 is software's fault; ignored here
         if (instrWord == OP_SET_PORT_D_BIT && regY <= PORT_D_MAX) portD_q[regY] <= 1'b1;
      end
   end

   // Bank and upper flags apart, so no bus write can block them
   // Only reset clears them; the clearing words live elsewhere
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         bank_q <= 1'b0;
         upper_q <= 1'b0;
      end else if (execNormal) begin
         if (instrWord == OP_SET_PAGE_BANK) bank_q <= 1'b1;
         if (instrWord == OP_SET_TABLE_UPPER) upper_q <= 1'b1;
      end
   end
   assign portD = portD_q;
   assign pageBankFlag = bank_q; // Only table reads use page bit 6
   assign tableHighBitsEnable = upper_q;

   // Request flags: set wins over any clear
   always_ff @(posedge clock or posedge reset) begin
      if (reset) flags_q <= '0;
      else begin
         for (int i = 0; i < NUM_FL; i++) begin
            if (flagSetPulse[i]) flags_q[i] <= 1'b1;
            else if (flagClr[i] || (apbWr && paddr == ADDR_FLAGS && pwdata[i]))
               flags_q[i] <= 1'b0;
         end
      end
   end
   assign requestFlags = flags_q;

   // Control registers
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ctrl1_q <= 4'h0;
         ctrl2_q <= 4'h0;
         pol_q <= 2'h0;
         evMsk_q <= '0;
      end else if (apbWr) begin
         case (paddr)
            ADDR_CTRL1:   ctrl1_q <= pwdata[3:0];
            ADDR_CTRL2:   ctrl2_q <= pwdata[3:0];
            ADDR_POL:     pol_q <= pwdata[1:0];
            ADDR_IRQ_MSK: evMsk_q <= pwdata[NUM_EV-1:0];
            default: ;
         endcase
      end
   end

   // Sticky events, write one to clear, set wins
   always_ff @(posedge clock or posedge reset) begin
      if (reset) evSt_q <= '0;
      else begin
         for (int i = 0; i < NUM_EV; i++) begin
            if ((i == EV_SKIP && instrValid && skip_d) || (i == EV_PORT_ERR && portErr))
               evSt_q[i] <= 1'b1;
            else if (apbWr && paddr == ADDR_IRQ_ST && pwdata[i]) evSt_q[i] <= 1'b0;
         end
      end
   end
   assign irq = |(evSt_q & evMsk_q);

   // Read data registered at setup phase
   always_ff @(posedge clock or posedge reset) begin
      if (reset) prdata_q <= 32'h0000_0000;
      else if (psel && !penable && !pwrite) begin
         case (paddr)
            ADDR_CTRL1:   prdata_q <= {28'h0, ctrl1_q};
            ADDR_CTRL2:   prdata_q <= {28'h0, ctrl2_q};
            ADDR_POL:     prdata_q <= {30'h0, pol_q};
            ADDR_STATUS:  prdata_q <= {28'h0, powerDownFlag, carryFlag, upper_q, bank_q};
            ADDR_FLAGS:   prdata_q <= {26'h0, flags_q};
            ADDR_IRQ_ST:  prdata_q <= {30'h0, evSt_q};
            ADDR_IRQ_MSK: prdata_q <= {30'h0, evMsk_q};
            ADDR_PORT_D:  prdata_q <= {27'h0, portD_q};
            ADDR_ACC:     prdata_q <= {28'h0, accumulator};
            default:      prdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // Two-word and skip sequencing
   AST_SKIP_DROPS: assert property (@(posedge clock) disable iff (reset)
      instrValid && state_q == EXEC_SKIP |=> state_q == EXEC_NORMAL)
      else $error("skip state not left");
   AST_SKIP_QUIET: assert property (@(posedge clock) disable iff (reset)
      instrValid && state_q == EXEC_SKIP && !apbWr
      |=> $stable(portD) && $stable(pageBankFlag) && $stable(tableHighBitsEnable) && !skipNext)
      else $error("skipped word had an effect");
   AST_IMM_WAIT: assert property (@(posedge clock) disable iff (reset)
      execNormal && instrWord == OP_SKIP_ACC_EQ_IMM |=> state_q == EXEC_WAIT_IMM)
      else $error("immediate word not awaited");
   AST_IMM_SKIP: assert property (@(posedge clock) disable iff (reset)
      instrValid && state_q == EXEC_WAIT_IMM
      |=> skipNext == ($past(accumulator) == $past(instrWord[3:0])))
      else $error("immediate compare wrong");
   AST_PORTD_SKIP: assert property (@(posedge clock) disable iff (reset)
      instrValid && state_q == EXEC_WAIT_PORTD
      |=> skipNext == !$past(portD_q[regY]))
      else $error("port D test wrong");

   // Skip outcomes of one-word tests, and the voltage flag kept by its test
   AST_MEM_EQ_SKIP: assert property (@(posedge clock) disable iff (reset)
      execNormal && instrWord == OP_SKIP_ACC_EQ_MEM
      |=> skipNext == ($past(accumulator) == $past(memNib)))
      else $error("memory compare wrong");
   AST_MEM_BIT_SKIP: assert property (@(posedge clock) disable iff (reset)
      execNormal && (instrWord & MASK_BIT_FIELD) == OP_TEST_MEM_BIT_ZERO
      |=> skipNext == !$past(memNib[instrWord[1:0]]))
      else $error("memory bit test wrong");
   AST_PIN0_SKIP: assert property (@(posedge clock) disable iff (reset)
      execNormal && instrWord == OP_TEST_PIN0
      |=> skipNext == ($past(pin0) == $past(pol_q[0])))
      else $error("pin0 test wrong");
   AST_PIN1_SKIP: assert property (@(posedge clock) disable iff (reset)
      execNormal && instrWord == OP_TEST_PIN1
      |=> skipNext == ($past(pin1) == $past(pol_q[1])))
      else $error("pin1 test wrong");
   AST_CARRY_SKIP: assert property (@(posedge clock) disable iff (reset)
      execNormal && instrWord == OP_TEST_CARRY_ZERO |=> skipNext == !$past(carryFlag))
      else $error("carry skip wrong");
   AST_PWR_SKIP: assert property (@(posedge clock) disable iff (reset)
      execNormal && instrWord == OP_TEST_POWER_DOWN |=> skipNext == $past(powerDownFlag))
      else $error("power-down skip wrong");
   AST_VDET_SKIP: assert property (@(posedge clock) disable iff (reset)
      execNormal && instrWord == OP_TEST_VDET && !ctrl2_q[EN_VDET]
      |=> skipNext == $past(flags_q[FL_VDET]))
      else $error("voltage test wrong");
   AST_VDET_KEEP: assert property (@(posedge clock) disable iff (reset)
      execNormal && instrWord == OP_TEST_VDET && flags_q[FL_VDET] |=> flags_q[FL_VDET])
      else $error("voltage flag lost");
   AST_EXT0_SKIP: assert property (@(posedge clock) disable iff (reset)
      execNormal && instrWord == OP_TEST_EXT0 && !ctrl1_q[EN_EXT0]
      |=> skipNext == $past(flags_q[FL_EXT0]))
      else $error("ext0 test wrong");
   AST_EXT1_SKIP: assert property (@(posedge clock) disable iff (reset)
      execNormal && instrWord == OP_TEST_EXT1 && !ctrl1_q[EN_EXT1]
      |=> skipNext == $past(flags_q[FL_EXT1]))
      else $error("ext1 test wrong");
   AST_T1_SKIP: assert property (@(posedge clock) disable iff (reset)
      execNormal && instrWord == OP_TEST_TIMER1 && !ctrl1_q[EN_TIMER1]
      |=> skipNext == $past(flags_q[FL_T1]))
      else $error("timer1 test wrong");
   AST_T3_SKIP: assert property (@(posedge clock) disable iff (reset)
      execNormal && instrWord == OP_TEST_TIMER3 && !ctrl2_q[EN_TIMER3]
      |=> skipNext == $past(flags_q[FL_T3]))
      else $error("timer3 test wrong");

   // Request flag clears
   AST_EXT0_CLR: assert property (@(posedge clock) disable iff (reset)
      execNormal && instrWord == OP_TEST_EXT0 && !ctrl1_q[EN_EXT0] && !flagSetPulse[FL_EXT0]
      |=> !flags_q[FL_EXT0])
      else $error("ext0 flag not cleared");
   AST_EXT1_CLR: assert property (@(posedge clock) disable iff (reset)
      execNormal && instrWord == OP_TEST_EXT1 && !ctrl1_q[EN_EXT1] && !flagSetPulse[FL_EXT1]
      |=> !flags_q[FL_EXT1])
      else $error("ext1 flag not cleared");
   AST_T1_CLR: assert property (@(posedge clock) disable iff (reset)
      execNormal && instrWord == OP_TEST_TIMER1 && !ctrl1_q[EN_TIMER1] && !flagSetPulse[FL_T1]
      |=> !flags_q[FL_T1])
      else $error("timer1 flag not cleared");
   AST_T2_CLR: assert property (@(posedge clock) disable iff (reset)
      execNormal && instrWord == OP_TEST_TIMER2 && !ctrl1_q[EN_TIMER2] && !flagSetPulse[FL_T2]
      |=> !flags_q[FL_T2] && skipNext == $past(flags_q[FL_T2]))
      else $error("timer2 test wrong");
   AST_T3_CLR: assert property (@(posedge clock) disable iff (reset)
      execNormal && instrWord == OP_TEST_TIMER3 && !ctrl2_q[EN_TIMER3] && !flagSetPulse[FL_T3]
      |=> !flags_q[FL_T3])
      else $error("timer3 flag not cleared");
   AST_SET_WINS: assert property (@(posedge clock) disable iff (reset)
      flagSetPulse != '0 |=> (requestFlags & $past(flagSetPulse)) == $past(flagSetPulse))
      else $error("flag set lost");

   // Set instructions
   AST_MEM_BIT_SET: assert property (@(posedge clock) disable iff (reset)
      execNormal && (instrWord & MASK_BIT_FIELD) == OP_SET_MEMORY_BIT
      |=> mem_q[$past(dataPointer)][$past(instrWord[1:0])])
      else $error("memory bit not set");
   AST_BANK_SET: assert property (@(posedge clock) disable iff (reset)
      execNormal && instrWord == OP_SET_PAGE_BANK |=> pageBankFlag)
      else $error("bank flag not set");
   AST_UPPER_SET: assert property (@(posedge clock) disable iff (reset)
      execNormal && instrWord == OP_SET_TABLE_UPPER |=> tableHighBitsEnable)
      else $error("upper flag not set");
   AST_PORTD_SET: assert property (@(posedge clock) disable iff (reset)
      execNormal && instrWord == OP_SET_PORT_D_BIT && regY <= PORT_D_MAX && !apbWr
      |=> portD[$past(regY)])
      else $error("port D bit not set");
   AST_PORT_ERR_KEEP: assert property (@(posedge clock) disable iff (reset)
      execNormal && instrWord == OP_SET_PORT_D_BIT && regY > PORT_D_MAX && !apbWr
      |=> $stable(portD))
      else $error("port D changed for bad Y");

   // Main scenarios for coverage
   COV_IMM_SKIP: cover property (@(posedge clock) state_q == EXEC_WAIT_IMM ##1 state_q == EXEC_SKIP);
   COV_PORTD: cover property (@(posedge clock) state_q == EXEC_WAIT_PORTD ##1 state_q == EXEC_SKIP);
   COV_IRQ: cover property (@(posedge clock) irq);
   COV_PORT_ERR: cover property (@(posedge clock) portErr);
   COV_PIN1_SKIP: cover property (@(posedge clock) execNormal && instrWord == OP_TEST_PIN1 ##1 skipNext);
endmodule : bit_skip_instr_unit

// >>> logic/bit_skip_pkg.sv
// Package for the bit-set and skip instruction unit of a 4-bit core.
// Assumes a 10-bit instruction word and an APB register port at 32 bits.
package bit_skip_pkg;
   // Opcodes (10-bit words)
   localparam logic [9:0] OP_SET_MEMORY_BIT     = 10'h05C; // low 2 bits select j
   localparam logic [9:0] OP_SET_PAGE_BANK      = 10'h047;
   localparam logic [9:0] OP_SET_PORT_D_BIT     = 10'h015;
   localparam logic [9:0] OP_SKIP_ACC_EQ_IMM    = 10'h025;
   localparam logic [9:0] OP_IMM_SECOND_WORD    = 10'h070; // low 4 bits hold n
   localparam logic [9:0] OP_SKIP_ACC_EQ_MEM    = 10'h026;
   localparam logic [9:0] OP_TEST_EXT0          = 10'h038;
   localparam logic [9:0] OP_TEST_EXT1          = 10'h039;
   localparam logic [9:0] OP_TEST_PIN0          = 10'h03A;
   localparam logic [9:0] OP_TEST_PIN1          = 10'h03B;
   localparam logic [9:0] OP_TEST_POWER_DOWN    = 10'h003;
   localparam logic [9:0] OP_TEST_TIMER1        = 10'h280;
   localparam logic [9:0] OP_TEST_TIMER2        = 10'h281;
   localparam logic [9:0] OP_TEST_TIMER3        = 10'h282;
   localparam logic [9:0] OP_TEST_VDET          = 10'h28A;
   localparam logic [9:0] OP_SET_TABLE_UPPER    = 10'h059;
   localparam logic [9:0] OP_TEST_MEM_BIT_ZERO  = 10'h020; // low 2 bits select j
   localparam logic [9:0] OP_TEST_CARRY_ZERO    = 10'h02F;
   localparam logic [9:0] OP_TEST_PORT_D_ZERO   = 10'h024;
   localparam logic [9:0] OP_PORT_D_SECOND_WORD = 10'h02B;
   localparam logic [9:0] MASK_BIT_FIELD        = 10'h3FC;
   localparam logic [9:0] MASK_NIBBLE_FIELD     = 10'h3F0;

   // Control bit positions
   localparam int EN_EXT0   = 0;
   localparam int EN_EXT1   = 1;
   localparam int EN_TIMER1 = 2;
   localparam int EN_TIMER2 = 3;
   localparam int EN_TIMER3 = 0;
   localparam int EN_VDET   = 3;
   localparam int POL_SEL   = 2;
   localparam int PAGE_BIT  = 6;
   localparam logic [2:0] PORT_D_MAX = 3'h4;

   // Request flag indices
   localparam int FL_EXT0 = 0;
   localparam int FL_EXT1 = 1;
   localparam int FL_T1   = 2;
   localparam int FL_T2   = 3;
   localparam int FL_T3   = 4;
   localparam int FL_VDET = 5;
   localparam int NUM_FL  = 6;

   // APB register byte addresses
   localparam logic [7:0] ADDR_CTRL1   = 8'h00; // enable bits [3:0]
   localparam logic [7:0] ADDR_CTRL2   = 8'h04; // enable bits [3:0]
   localparam logic [7:0] ADDR_POL     = 8'h08; // [0] pin0 pol, [1] pin1 pol
   localparam logic [7:0] ADDR_STATUS  = 8'h0C; // [0] bank [1] upper [2] carry [3] pdown
   localparam logic [7:0] ADDR_FLAGS   = 8'h10; // request flags, write 1 clears
   localparam logic [7:0] ADDR_IRQ_ST  = 8'h14; // sticky events, write 1 clears
   localparam logic [7:0] ADDR_IRQ_MSK = 8'h18;
   localparam logic [7:0] ADDR_PORT_D  = 8'h1C;
   localparam logic [7:0] ADDR_ACC     = 8'h20;

   // Interrupt event bits
   localparam int EV_SKIP    = 0;
   localparam int EV_PORT_ERR = 1;
   localparam int NUM_EV     = 2;

   typedef enum logic [1:0] {EXEC_NORMAL, EXEC_WAIT_IMM, EXEC_WAIT_PORTD, EXEC_SKIP} exec_t;
endpackage : bit_skip_pkg

// >>> test/tb.sv
// Self-checking bench for the bit-set and skip unit, random and corner runs.
// Assumes a zero-wait APB slave and a registered skipNext for each word.
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module tb
   import bit_skip_pkg::*;
;
   logic              clock = 1'b0;
   logic              reset = 1'b1;
   logic              instrValid = 1'b0;
   logic              carryFlag = 1'b0;
   logic              powerDownFlag = 1'b0;
   logic              extIrq0Pin = 1'b0;
   logic              extIrq1Pin = 1'b0;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [9:0]        instrWord = 10'h000;
   logic [5:0]        dataPointer = 6'h00;
   logic [2:0]        regY = 3'h2;
   logic [3:0]        accumulator = 4'h0;
   logic [NUM_FL-1:0] flagSetPulse = '0;
   logic [7:0]        paddr = 8'h00;
   logic [31:0]       pwdata = 32'h0;
   logic [31:0]       prdata;
   logic [31:0]       rd;
   logic              pready;
   logic              pslverr;
   logic              skipNext;
   logic              pageBankFlag;
   logic              tableHighBitsEnable;
   logic              irq;
   logic [4:0]        portD;
   logic [4:0]        expD;
   logic [NUM_FL-1:0] requestFlags;
   logic [3:0]        a;
   logic [3:0]        n;
   int                n_mismatch = 0;
   int                total_checks = 0;
   // Same order as the request flag indices
   localparam logic [9:0] OPS [NUM_FL] = '{OP_TEST_EXT0, OP_TEST_EXT1, OP_TEST_TIMER1,
                                           OP_TEST_TIMER2, OP_TEST_TIMER3, OP_TEST_VDET};
   localparam int EN [NUM_FL] = '{EN_EXT0, EN_EXT1, EN_TIMER1, EN_TIMER2, EN_TIMER3, EN_VDET};

   bit_skip_instr_unit #(.MEM_AW(6)) i_bit_skip_instr_unit (
      .clock(clock), .reset(reset), .instrValid(instrValid), .instrWord(instrWord),
      .dataPointer(dataPointer), .regY(regY), .accumulator(accumulator),
      .carryFlag(carryFlag), .powerDownFlag(powerDownFlag), .extIrq0Pin(extIrq0Pin),
      .extIrq1Pin(extIrq1Pin), .flagSetPulse(flagSetPulse), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .skipNext(skipNext), .portD(portD), .pageBankFlag(pageBankFlag),
      .tableHighBitsEnable(tableHighBitsEnable), .requestFlags(requestFlags), .irq(irq));

   initial begin
      forever #4 clock = ~clock;
   end

   function automatic logic pinSkip(input logic pin, input logic pol);
      return pin == pol;
   endfunction : pinSkip

   function automatic logic flagAfter(input int f, input int e);
      return (e == 1) || (f == FL_VDET);
   endfunction : flagAfter

   task automatic report_and_stop;
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop

   // Waits on pready under a bound; a hung slave ends the run
   task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20 && pready !== 1'b1) begin
         n_mismatch++;
         report_and_stop();
      end else begin
         rd = prdata;
         `CHK(pslverr, 1'b0)
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb

   // Filler word always follows, so a pending skip never leaks into the next case
   task automatic runSkip(input logic [9:0] w, input logic e, input logic [9:0] w2 = 10'h000,
                          input logic two = 1'b0, input logic [9:0] fill = 10'h000);
      @(posedge clock);
      instrValid <= 1'b1;
      instrWord <= w;
      if (two) begin
         @(posedge clock);
         instrWord <= w2;
      end
      @(posedge clock);
      instrValid <= 1'b0;
      @(negedge clock);
      `CHK(skipNext, e)
      @(posedge clock);
      instrValid <= 1'b1;
      instrWord <= fill;
      @(posedge clock);
      instrValid <= 1'b0;
      @(negedge clock);
   endtask : runSkip

   initial begin
      repeat (50000) @(posedge clock);
      n_mismatch++;
      report_and_stop();
   end

   initial begin
      void'($urandom(34888));
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      @(negedge clock);
      `CHK({portD, pageBankFlag, tableHighBitsEnable, requestFlags, irq, skipNext}, 15'h0)
      runSkip(OP_TEST_CARRY_ZERO, 1'b1, 10'h000, 1'b0, OP_SET_PORT_D_BIT);
      `CHK(portD, 5'h00)
      @(posedge clock) carryFlag <= 1'b1;
      runSkip(OP_TEST_CARRY_ZERO, 1'b0);
      @(posedge clock) regY <= 3'($urandom_range(4));
      runSkip(OP_TEST_PORT_D_ZERO, 1'b1, OP_PORT_D_SECOND_WORD, 1'b1);
      expD = 5'h00;
      for (int i = 0; i < 5; i++) begin
         @(posedge clock) regY <= 3'(i);
         runSkip(OP_SET_PORT_D_BIT, 1'b0);
         expD[i] = 1'b1;
         `CHK(portD, expD)
      end
      @(posedge clock) regY <= 3'($urandom_range(4));
      runSkip(OP_TEST_PORT_D_ZERO, 1'b0, OP_PORT_D_SECOND_WORD, 1'b1);
      @(posedge clock) regY <= 3'h5;
      runSkip(OP_SET_PORT_D_BIT, 1'b0);
      runSkip(OP_SET_PAGE_BANK, 1'b0);
      `CHK(pageBankFlag, 1'b1)
      runSkip(OP_SET_TABLE_UPPER, 1'b0);
      `CHK(tableHighBitsEnable, 1'b1)
      @(posedge clock) dataPointer <= 6'($urandom());
      for (int j = 0; j < 4; j++) begin
         runSkip(OP_SET_MEMORY_BIT | 10'(j), 1'b0);
         runSkip(OP_TEST_MEM_BIT_ZERO | 10'(j), 1'b0);
      end
      @(posedge clock) accumulator <= 4'hF;
      runSkip(OP_SKIP_ACC_EQ_MEM, 1'b1);
      @(posedge clock) accumulator <= 4'($urandom_range(14));
      runSkip(OP_SKIP_ACC_EQ_MEM, 1'b0);
      for (int i = 0; i < 10; i++) begin
         a = (i == 0) ? 4'h0 : 4'($urandom());
         n = (i % 2) ? 4'($urandom()) : a;
         @(posedge clock) accumulator <= a;
         runSkip(OP_SKIP_ACC_EQ_IMM, a == n, OP_IMM_SECOND_WORD | 10'(n), 1'b1);
      end
      for (int i = 0; i < 2; i++) begin
         @(posedge clock) powerDownFlag <= i[0];
         runSkip(OP_TEST_POWER_DOWN, i[0]);
      end
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, ADDR_POL, {30'h0, i[1], i[1]});
         @(posedge clock) extIrq0Pin <= i[0];
         extIrq1Pin <= i[0];
         repeat (3) @(posedge clock);
         runSkip(i[2] ? OP_TEST_PIN1 : OP_TEST_PIN0, pinSkip(i[0], i[1]));
      end
      for (int f = 0; f < NUM_FL; f++) begin
         for (int e = 0; e < 2; e++) begin
            apb(1'b1, (f < 4) ? ADDR_CTRL1 : ADDR_CTRL2, 32'h1 << EN[f]);
            if (e == 0) apb(1'b1, (f < 4) ? ADDR_CTRL1 : ADDR_CTRL2, 32'h0);
            @(posedge clock) flagSetPulse[f] <= 1'b1;
            @(posedge clock) flagSetPulse <= '0;
            runSkip(OPS[f], e == 0);
            `CHK(requestFlags[f], flagAfter(f, e))
            apb(1'b1, ADDR_FLAGS, 32'h1 << f);
            if (e == 0) runSkip(OPS[f], 1'b0);
         end
      end
      // Events stay sticky while masked; irq follows both the events and the mask
      apb(1'b0, ADDR_IRQ_ST, 32'h0);
      `CHK(rd[1:0], 2'h3)
      `CHK(irq, 1'b0)
      apb(1'b1, ADDR_IRQ_MSK, 32'h1);
      @(negedge clock);
      `CHK(irq, 1'b1)
      apb(1'b1, ADDR_IRQ_ST, 32'h3);
      @(negedge clock);
      `CHK(irq, 1'b0)
      apb(1'b0, 8'h40, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'b0, ADDR_ACC, 32'h0);
      `CHK(rd, {28'h0, accumulator})
      apb(1'b0, ADDR_STATUS, 32'h0);
      `CHK(rd, 32'h0000_000F)
      expD = 5'($urandom());
      apb(1'b1, ADDR_PORT_D, {27'h0, expD});
      @(negedge clock);
      `CHK(portD, expD)
      @(posedge clock) regY <= 3'($urandom_range(4));
      @(negedge clock);
      runSkip(OP_TEST_PORT_D_ZERO, !expD[regY], OP_PORT_D_SECOND_WORD, 1'b1);
      report_and_stop();
   end
endmodule : tb
